// File: hw/ulpi_port_pkg.sv
// Package with constants and types for the ULPI register and receive command port.
package ulpi_port_pkg;

  // ****************************************
  // Command byte encoding
  // ****************************************
  localparam logic [1:0] CMD_IDLE = 2'h0;
  localparam logic [1:0] CMD_TRANSMIT = 2'h1;
  localparam logic [1:0] CMD_REG_WRITE = 2'h2;
  localparam logic [1:0] CMD_REG_READ = 2'h3;
  localparam logic [7:0] BUS_IDLE = 8'h00;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [5:0] ADDR_IRQ_LATCH = 6'h14;
  localparam logic [5:0] ADDR_LINE_STATE_DEBUG = 6'h15;
  localparam logic [5:0] ADDR_SCRATCH_WRITE = 6'h16;
  localparam logic [5:0] ADDR_SCRATCH_SET = 6'h17;
  localparam logic [5:0] ADDR_SCRATCH_CLEAR = 6'h18;
  localparam logic [5:0] ADDR_VENDOR_FIRST = 6'h30;
  localparam logic [5:0] ADDR_VENDOR_LAST = 6'h3f;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [4:0] IRQ_LATCH_RESET = 5'h00;
  localparam logic [4:0] IRQ_ENABLE_RESET = 5'h1f;

  // ****************************************
  // Receive command field values
  // ****************************************
  localparam logic [1:0] VBUS_BELOW_END = 2'h0;
  localparam logic [1:0] VBUS_END_TO_SESS = 2'h1;
  localparam logic [1:0] VBUS_SESS_TO_VALID = 2'h2;
  localparam logic [1:0] VBUS_ABOVE_VALID = 2'h3;
  localparam logic [1:0] RXEV_NONE = 2'h0;
  localparam logic [1:0] RXEV_ACTIVE = 2'h1;
  localparam logic [1:0] RXEV_ERROR = 2'h3;
  localparam logic [1:0] RXEV_DISCONNECT = 2'h2;

  // Analogue status sampled from the transceiver.
  typedef struct packed {
    logic idPin;
    logic hostDisconnect;
    logic vbusValid;
    logic sessValid;
    logic sessEnd;
    logic rxError;
    logic rxActive;
    logic line_state_bit_high;
    logic line_state_bit_low;
  } phy_status_t;

  // Receive command byte layout.
  typedef struct packed {
    logic reserved;
    logic idState;
    logic [1:0] rxEvent;
    logic [1:0] vbusState;
    logic [1:0] lineState;
  } rx_cmd_t;

  // Decoded transmit start.
  typedef struct packed {
    logic start;
    logic hasPid;
    logic [3:0] pid;
  } tx_start_t;

endpackage : ulpi_port_pkg

// File: hw/ulpi_register_and_rxcmd_port.sv
// PHY side ULPI command decoder, register handshakes and receive command generator.
//
// Behaviour
// - Debug register returns line state, zeros above.
// - Scratch byte writable, settable, clearable, readable.
// - Command 01 starts transmit with optional PID.
// - Command 10 is register write to address.
// - Command 11 is register read from address.
// - Write handshake: next, data, stop, next drops.
// - Direction stays low during register write.
// - Written value stored after stop deasserts.
// - Read: next, then direction up, next down.
// - Drive register data one cycle, release bus.
// - Line change while idle sends receive command.
// - Receive: command byte when direction high, next low.
// - Transmit: receive commands only after stop.
// - VBUS or ID change sends receive command.
// - Bits 1:0 carry line state bits.
// - Bits 3:2 encode VBUS level.
// - Bits 5:4 encode receive events.
// - Bit 6 mirrors ID pin level.
// - Reading latched status clears its bits.
`timescale 1ns/1ps
`default_nettype none

module ulpi_register_and_rxcmd_port (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // ULPI link pins.
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe_b,
  output logic dir,
  output logic nxt,
  input wire logic stp,
  // Transceiver status.
  input wire ulpi_port_pkg::phy_status_t phyStatus,
  // Transmit start towards the packet path.
  output ulpi_port_pkg::tx_start_t txStart
);
  import ulpi_port_pkg::*;

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rstMeta_b;
  logic rstSync_b;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  typedef enum {
    ST_IDLE, ST_WR_NXT, ST_WR_DATA, ST_WR_STOP, ST_RD_NXT, ST_RD_TURN, ST_RD_DATA,
    ST_TX, ST_RX_TURN, ST_RX_CMD
  } state_t;

  state_t state;
  state_t next_state;
  logic [5:0] addr;
  logic [7:0] wrData;
  logic [7:0] scratch;
  logic [4:0] irqLatch;
  phy_status_t lastStatus;
  logic rxPending;

  // ****************************************
  // Command decode
  // ****************************************
  wire [1:0] cmdKind = dataIn[7:6];
  wire cmdSeen = (state == ST_IDLE) && (cmdKind != CMD_IDLE);
  wire txNoPid = (dataIn[5:0] == 6'h00);
  wire [3:0] txPid = dataIn[3:0];

  // ****************************************
  // Receive command encoding
  // ****************************************
  // VBUS level encode
  wire [1:0] vbusCode = phyStatus.vbusValid ? VBUS_ABOVE_VALID :
                        phyStatus.sessValid ? VBUS_SESS_TO_VALID :
                        phyStatus.sessEnd ? VBUS_BELOW_END : VBUS_END_TO_SESS;
  wire [1:0] rxEvCode = phyStatus.hostDisconnect ? RXEV_DISCONNECT :
                        (phyStatus.rxActive && phyStatus.rxError) ? RXEV_ERROR :
                        phyStatus.rxActive ? RXEV_ACTIVE : RXEV_NONE;
  rx_cmd_t rxCmd;
  assign rxCmd.lineState = {phyStatus.line_state_bit_high, phyStatus.line_state_bit_low};
  assign rxCmd.vbusState = vbusCode;
  assign rxCmd.rxEvent = rxEvCode;
  assign rxCmd.idState = phyStatus.idPin;
  assign rxCmd.reserved = 1'b0;

  wire lineChange = {phyStatus.line_state_bit_high, phyStatus.line_state_bit_low} !=
                    {lastStatus.line_state_bit_high, lastStatus.line_state_bit_low};
  wire compChange = (phyStatus.vbusValid != lastStatus.vbusValid) ||
                    (phyStatus.sessValid != lastStatus.sessValid) ||
                    (phyStatus.sessEnd != lastStatus.sessEnd) ||
                    (phyStatus.idPin != lastStatus.idPin);
  wire rxWant = lineChange || compChange || rxPending;

  // Event sources for the latched status: disconnect, vbus, sess, end, id.
  wire [4:0] evNow = {phyStatus.idPin, phyStatus.sessEnd, phyStatus.sessValid,
                      phyStatus.vbusValid, phyStatus.hostDisconnect};
  wire [4:0] evLast = {lastStatus.idPin, lastStatus.sessEnd, lastStatus.sessValid,
                       lastStatus.vbusValid, lastStatus.hostDisconnect};
  wire [4:0] evRise = evNow & ~evLast & IRQ_ENABLE_RESET;
  wire [4:0] evFall = ~evNow & evLast & IRQ_ENABLE_RESET;
  wire [4:0] evHit = evRise | evFall;

  // ****************************************
  // Register read mux
  // ****************************************
  // debug register
  wire [7:0] debugValue = {6'h00, phyStatus.line_state_bit_high, phyStatus.line_state_bit_low};
  wire readScratch = (addr == ADDR_SCRATCH_WRITE) || (addr == ADDR_SCRATCH_SET) ||
                     (addr == ADDR_SCRATCH_CLEAR);
  wire [7:0] readValue = (addr == ADDR_LINE_STATE_DEBUG) ? debugValue :
                         (addr == ADDR_IRQ_LATCH) ? {3'h0, irqLatch} :
                         readScratch ? scratch : 8'h00;
  wire irqReadClear = (state == ST_RD_DATA) && (addr == ADDR_IRQ_LATCH);

  // ****************************************
  // Scratch write decode
  // ****************************************
  // commit after stop falls
  wire commit = (state == ST_WR_STOP) && !stp;
  wire [7:0] scratchNew = (addr == ADDR_SCRATCH_WRITE) ? wrData :
                          (addr == ADDR_SCRATCH_SET) ? (scratch | wrData) :
                          (addr == ADDR_SCRATCH_CLEAR) ? (scratch & ~wrData) : scratch;

  // ****************************************
  // Protocol state machine
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmdKind == CMD_REG_WRITE) begin
          next_state = ST_WR_NXT;
        end else if (cmdKind == CMD_REG_READ) begin
          next_state = ST_RD_NXT;
        end else if (cmdKind == CMD_TRANSMIT) begin
          next_state = ST_TX;
        end else if (rxWant) begin
          next_state = ST_RX_TURN;
        end
      end
      ST_WR_NXT: begin
        next_state = ST_WR_DATA;
      end
      ST_WR_DATA: begin
        if (stp) begin
          next_state = ST_WR_STOP;
        end
      end
      ST_WR_STOP: begin
        if (!stp) begin
          next_state = ST_IDLE;
        end
      end
      ST_RD_NXT: begin
        next_state = ST_RD_TURN;
      end
      ST_RD_TURN: begin
        next_state = ST_RD_DATA;
      end
      ST_RD_DATA: begin
        next_state = ST_IDLE;
      end
      ST_TX: begin
        if (stp) begin
          next_state = ST_RX_TURN;
        end
      end
      ST_RX_TURN: begin
        next_state = ST_RX_CMD;
      end
      ST_RX_CMD: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Registered pin values for the next cycle.
  // direction low while writing
  wire next_dir = (next_state == ST_RD_TURN) || (next_state == ST_RD_DATA) ||
                  (next_state == ST_RX_TURN) || (next_state == ST_RX_CMD);
  wire next_nxt = (next_state == ST_WR_NXT) || (next_state == ST_WR_DATA) ||
                  (next_state == ST_RD_NXT) || (next_state == ST_TX);
  wire next_oe = (next_state == ST_RD_DATA) || (next_state == ST_RX_CMD);
  wire [7:0] next_dataOut = (next_state == ST_RD_DATA) ? readValue :
                            (next_state == ST_RX_CMD) ? rxCmd : BUS_IDLE;

  // ****************************************
  // Register update controls
  // ****************************************
  wire captureData = (state == ST_WR_DATA) && !stp;
  wire txSeen = cmdSeen && (cmdKind == CMD_TRANSMIT);
  wire statusEvent = lineChange || compChange;
  wire rxSent = (state == ST_RX_CMD);
  wire [4:0] next_irqLatch = (irqReadClear ? 5'h00 : irqLatch) | evHit;

  // ****************************************
  // Protocol registers
  // ****************************************
  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      dir <= 1'b0;
    end else begin
      dir <= next_dir;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      nxt <= 1'b0;
    end else begin
      nxt <= next_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      dataOe_b <= 1'b1;
    end else begin
      dataOe_b <= !next_oe;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      dataOut <= BUS_IDLE;
    end else begin
      dataOut <= next_dataOut;
    end
  end

  // ****************************************
  // Command capture registers
  // ****************************************
  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      addr <= 6'h00;
    end else if (cmdSeen) begin
      addr <= dataIn[5:0];
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      wrData <= 8'h00;
    end else if (captureData) begin
      wrData <= dataIn;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      txStart <= '0;
    end else begin
      txStart.start <= txSeen;
      txStart.hasPid <= !txNoPid;
      txStart.pid <= txPid;
    end
  end

  // ****************************************
  // Scratch and status registers
  // ****************************************
  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      scratch <= SCRATCH_RESET;
    end else if (commit) begin
      scratch <= scratchNew;
    end
  end

  // Sets win over the read clear.
  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      irqLatch <= IRQ_LATCH_RESET;
    end else begin
      irqLatch <= next_irqLatch;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      lastStatus <= '0;
    end else begin
      lastStatus <= phyStatus;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      rxPending <= 1'b0;
    end else if (rxSent) begin
      rxPending <= statusEvent;
    end else if (statusEvent) begin
      rxPending <= 1'b1;
    end
  end

endmodule : ulpi_register_and_rxcmd_port

`default_nettype wire

// File: test/ulpi_port_chk.sv
// Assertions on the pins of the ULPI register and receive command port.
`timescale 1ns/1ps
`default_nettype none
module ulpi_port_chk (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Link pins and status.
  input wire logic [7:0] dataIn,
  input wire logic [7:0] dataOut,
  input wire logic dataOe_b,
  input wire logic dir,
  input wire logic nxt,
  input wire logic stp,
  input wire ulpi_port_pkg::phy_status_t phyStatus,
  input wire ulpi_port_pkg::tx_start_t txStart
);
  import ulpi_port_pkg::*;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  wire logic idle = !dir && !nxt;
  wire logic [5:0] statusWatched = {phyStatus.idPin, phyStatus.vbusValid, phyStatus.sessValid,
                                    phyStatus.sessEnd, phyStatus.line_state_bit_high,
                                    phyStatus.line_state_bit_low};
  sequence s_cmd(logic [1:0] k);
    idle && dataIn[7:6] == k;
  endsequence
  sequence s_readBack;
    nxt ##1 (dir && !nxt && dataOe_b) ##1 (dir && !dataOe_b) ##1 (!dir && dataOe_b);
  endsequence
  sequence s_rxSend;
    (dir && dataOe_b) ##1 (dir && !dataOe_b) ##1 !dir;
  endsequence
  a_write_next: assert property (s_cmd(2'h2) |=> (nxt && !dir) ##1 nxt)
    else $error("write command not answered by next");
  a_write_dir_low: assert property (s_cmd(2'h2) |=> !dir [*5])
    else $error("direction rose during a register write");
  a_read_turn: assert property (s_cmd(2'h3) |=> s_readBack)
    else $error("register read turnaround out of order");
  a_debug_value: assert property (s_cmd(2'h3) && dataIn[5:0] == ADDR_LINE_STATE_DEBUG
    |-> ##3 dataOut == {6'h00, $past(phyStatus.line_state_bit_high),
    $past(phyStatus.line_state_bit_low)})
    else $error("debug register value wrong");
  a_tx_start: assert property (s_cmd(2'h1) |=> txStart.start
    && txStart.pid == $past(dataIn[3:0]) && txStart.hasPid == ($past(dataIn[5:0]) != 6'h00))
    else $error("transmit start fields wrong");
  a_rx_take: assert property (idle && !stp && !$past(stp) && dataIn == 8'h00
    && $changed(statusWatched) |=> s_rxSend)
    else $error("status change not reported");
  a_rx_fields: assert property (dir && !dataOe_b && !$past(nxt, 2) |-> dataOut[7] == 1'b0
    && dataOut[6] == $past(phyStatus.idPin)
    && dataOut[1:0] == $past({phyStatus.line_state_bit_high, phyStatus.line_state_bit_low}))
    else $error("receive command fields wrong");
  a_drive_owned: assert property (!dataOe_b |-> dir)
    else $error("bus driven without direction");
endmodule : ulpi_port_chk
bind ulpi_register_and_rxcmd_port ulpi_port_chk chk (.mclk, .rst_b, .dataIn, .dataOut, .dataOe_b,
  .dir, .nxt, .stp, .phyStatus, .txStart);
`default_nettype wire

// File: test/ulpi_link_model.sv
// Link controller model that issues commands and register transfers.
`timescale 1ns/1ps
`default_nettype none
module ulpi_link_model (
  // Clock.
  input wire logic mclk,
  // Pins from the port.
  input wire logic dir,
  input wire logic nxt,
  input wire logic dataOe_b,
  input wire logic [7:0] dataOut,
  // Pins towards the port.
  output logic [7:0] dataIn,
  output logic stp
);
  logic [7:0] drv = 8'h00;
  initial stp = 1'b0;
  // bus level from both drivers, idle after transfers.
  assign dataIn = !dataOe_b ? dataOut : dir ? ~drv : drv;
  task automatic waitSig(input bit onDir, input logic want);
    for (int i = 0; i < 20 && (onDir ? dir : nxt) !== want; i++) @(negedge mclk);
  endtask : waitSig
  task automatic regWrite(input logic [5:0] a, input logic [7:0] d);
    @(negedge mclk);
    waitSig(1'b1, 1'b0);
    drv = {2'h2, a};
    waitSig(1'b0, 1'b1);
    @(negedge mclk);
    drv = d;
    @(negedge mclk);
    drv = 8'h00;
    stp = 1'b1;
    @(negedge mclk);
    stp = 1'b0;
    waitSig(1'b0, 1'b0);
  endtask : regWrite
  task automatic regRead(input logic [5:0] a, output logic [7:0] d);
    @(negedge mclk);
    waitSig(1'b1, 1'b0);
    drv = {2'h3, a};
    for (int i = 0; i < 20 && !(dir === 1'b1 && dataOe_b === 1'b0); i++) @(negedge mclk);
    d = dataOut;
    @(negedge mclk);
    drv = 8'h00;
  endtask : regRead
  task automatic txSend(input logic [5:0] f);
    @(negedge mclk);
    waitSig(1'b1, 1'b0);
    drv = {2'h1, f};
    waitSig(1'b0, 1'b1);
  endtask : txSend
  task automatic txStop();
    @(negedge mclk);
    drv = 8'h00;
    stp = 1'b1;
    @(negedge mclk);
    stp = 1'b0;
  endtask : txStop
endmodule : ulpi_link_model
`default_nettype wire

// File: test/tb_top.sv
// Self-checking testbench for the ULPI register and receive command port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ulpi_port_pkg::*;
  logic mclk, rst_b, dataOe_b, dir, nxt, stp;
  logic [7:0] dataIn, dataOut, rd, sc, m;
  phy_status_t phyStatus;
  tx_start_t txStart;
  int fails = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h5a99;
  ulpi_register_and_rxcmd_port dut (.mclk, .rst_b, .dataIn, .dataOut, .dataOe_b, .dir, .nxt,
    .stp, .phyStatus, .txStart);
  ulpi_link_model link (.mclk, .dir, .nxt, .dataOe_b, .dataOut, .dataIn, .stp);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] rxExp(input phy_status_t s);
    logic [1:0] v, e;
    v = s.vbusValid ? 2'h3 : s.sessValid ? 2'h2 : s.sessEnd ? 2'h0 : 2'h1;
    e = s.hostDisconnect ? 2'h2 : !s.rxActive ? 2'h0 : {s.rxError, 1'b1};
    return {1'b0, s.idPin, e, v, s.line_state_bit_high, s.line_state_bit_low};
  endfunction : rxExp
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("Mismatches %0d, comparisons %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  task automatic waitRx(input phy_status_t s);
    for (int i = 0; i < 12 && !(dir === 1'b1 && dataOe_b === 1'b0); i++) @(negedge mclk);
    check("rx cmd", dataOut, rxExp(s));
    check("rx drive", {7'h00, dataOe_b}, 8'h00);
  endtask : waitRx
  task automatic rxSee(input phy_status_t s);
    @(negedge mclk);
    phyStatus = s;
    waitRx(s);
  endtask : rxSee
  // The sequence needs about 340 cycles, so 100 us leaves wide margin.
  initial begin
    #100us;
    fails++;
    stop_test();
  end
  initial begin
    phy_status_t s;
    logic [5:0] f;
    rst_b = 1'b0;
    phyStatus = '0;
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    check("reset pins", {dataOe_b, dir, nxt, 5'h00}, 8'h80);
    link.regRead(ADDR_SCRATCH_WRITE, rd);
    check("scratch reset", rd, SCRATCH_RESET);
    link.regRead(ADDR_IRQ_LATCH, rd);
    check("latch reset", rd, 8'h00);
    s = '0;
    s.vbusValid = 1'b1;
    rxSee(s);
    link.regRead(ADDR_IRQ_LATCH, rd);
    check("latch set", rd, 8'h02);
    link.regRead(ADDR_IRQ_LATCH, rd);
    check("latch clear", rd, 8'h00);
    for (int i = 0; i < 12; i++) begin
      s = phy_status_t'(9'(rnd()));
      s.line_state_bit_low = ~phyStatus.line_state_bit_low;
      rxSee(s);
      link.regRead(ADDR_LINE_STATE_DEBUG, rd);
      check("debug", rd, {6'h00, s.line_state_bit_high, s.line_state_bit_low});
      m = (i == 5) ? 8'hff : 8'(rnd());
      link.regWrite(ADDR_SCRATCH_WRITE + 6'(i % 3), m);
      sc = (i % 3 == 0) ? m : (i % 3 == 1) ? (sc | m) : (sc & ~m);
      link.regWrite(ADDR_LINE_STATE_DEBUG - 6'(i % 2), ~m);
      link.regRead(ADDR_SCRATCH_WRITE + 6'(i % 3), rd);
      check("scratch", rd, sc);
    end
    for (int i = 0; i < 3; i++) begin
      f = (i == 0) ? 6'h00 : {2'h0, 4'(rnd())};
      link.txSend(f);
      check("tx start", {2'h0, txStart}, {3'h1, f != 6'h00, f[3:0]});
      s.line_state_bit_low = ~s.line_state_bit_low;
      phyStatus = s;
      repeat (3) begin
        @(negedge mclk);
        check("tx quiet", {7'h00, dir}, 8'h00);
      end
      link.txStop();
      waitRx(s);
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
